// [epu_pkg.sv]
// Shared constants and carrier types of the exception priority unit.
// Assumes one system clock; the core and fault sources sit outside this unit.
`default_nettype none

package epu_pkg;

  // Sizes of the exception space
  localparam int NUM_POS  = 64;
  localparam int POS_W    = 6;
  localparam int PRIO_W   = 3;
  localparam int RANK_W   = 5;
  localparam int IRQ_NUM  = 48;

  // Exception positions
  localparam logic [5:0] POS_STACK_TOP = 6'h00;
  localparam logic [5:0] POS_RESET     = 6'h01;
  localparam logic [5:0] POS_NMI       = 6'h02;
  localparam logic [5:0] POS_HARD      = 6'h03;
  localparam logic [5:0] POS_MEM       = 6'h04;
  localparam logic [5:0] POS_BUS       = 6'h05;
  localparam logic [5:0] POS_USAGE     = 6'h06;
  localparam logic [5:0] POS_SVC       = 6'h0b;
  localparam logic [5:0] POS_DEBUG     = 6'h0c;
  localparam logic [5:0] POS_PENDABLE_SERVICE_REQUEST    = 6'h0e;
  localparam logic [5:0] POS_TICK      = 6'h0f;
  localparam logic [5:0] POS_IRQ_BASE  = 6'h10;

  // Implemented peripheral bits and system positions
  localparam logic [47:0] IRQ_VALID   = 48'h0081_ffff_c1ff;
  localparam logic [15:0] SYS_SETTABLE = 16'hd870;
  localparam logic [15:0] SYS_PENDABLE = 16'hd87c;

  // Rank encoding: fixed levels first, settable levels after, idle level last
  localparam logic [4:0] RANK_SETTABLE_BASE = 5'h03;
  localparam logic [4:0] RANK_BASE_LEVEL    = 5'h1f;
  localparam logic [2:0] PRIO_RESET         = 3'h0;
  localparam logic [2:0] PRIGROUP_SUB_START = 3'h4;

  // Mapped address windows outside flash and SRAM
  localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
  localparam int MAP_N = 14;
  localparam logic [31:0] MAP_LO [MAP_N] = '{
    32'h2200_0000, 32'h4000_0000, 32'h4000_4000, 32'h4000_c000, 32'h4002_0000,
    32'h4002_4000, 32'h4003_0000, 32'h4003_8000, 32'h4003_c000, 32'h4004_0000,
    32'h400f_d000, 32'h4200_0000, 32'he000_0000, 32'he000_e000};
  localparam logic [31:0] MAP_HI [MAP_N] = '{
    32'h23ff_ffff, 32'h4000_0fff, 32'h4000_8fff, 32'h4000_dfff, 32'h4002_0fff,
    32'h4002_7fff, 32'h4003_2fff, 32'h4003_8fff, 32'h4003_cfff, 32'h4004_0fff,
    32'h400f_efff, 32'h43ff_ffff, 32'he000_2fff, 32'he000_efff};
  localparam logic [31:0] TRACE_LO = 32'he004_0000;
  localparam logic [31:0] TRACE_HI = 32'he004_0fff;

  // Sequencer phases
  typedef enum logic [2:0] {
    PH_SP_LOAD, PH_RST_VEC, PH_RESET_RUN, PH_RUN, PH_ENTRY, PH_EXIT, PH_UNSTACK
  } phase_t;

  // System exception events, one-cycle pulses
  typedef struct packed {
    logic nmi_set;
    logic mem_fault;
    logic bus_fault;
    logic usage_fault;
    logic svc;
    logic debug_event;
    logic pendable_service_request_set;
    logic tick;
  } sys_evt_t;

  // Handler enables
  typedef struct packed {
    logic mem_en;
    logic bus_en;
    logic usage_en;
    logic debug_en;
  } fault_en_t;

  // Memory access to be checked against the map
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } bus_acc_t;

  // Commands to the core
  typedef struct packed {
    logic       sp_load;
    logic       stack_push;
    logic       unstack;
    logic       vec_fetch;
    logic [5:0] vec_num;
  } core_cmd_t;

  // Whole state of the unit
  typedef struct packed {
    phase_t           phase;
    logic [63:0][2:0] prio;
    logic [63:0]      pend;
    logic [63:0]      active;
    logic             handler;
    logic [5:0]       cur_num;
    core_cmd_t        cmd;
    logic             stack_ok;
    logic             fetch_ok;
    logic             bus_fault_resp;
  } state_t;

endpackage

`default_nettype wire

// [priority_resolver.sv]
// Picks the most urgent requesting position out of the exception space.
// Assumes ranks are already encoded so that a lower rank is more urgent.
`default_nettype none

module priority_resolver (
  // Requests and their ranks
  input  wire logic [63:0]      req_i,
  input  wire logic [63:0][4:0] rank_i,
  // Winner
  output logic                  found_o,
  output logic [5:0]            num_o,
  output logic [4:0]            rank_o
);

  // Strict compare keeps the lowest position on equal rank
  always_comb begin
    found_o = 1'b0;
    num_o   = 6'h00;
    rank_o  = epu_pkg::RANK_BASE_LEVEL;
    for (int i = 0; i < epu_pkg::NUM_POS; i++) begin
      if (req_i[i] && (!found_o || rank_i[i] < rank_o)) begin
        found_o = 1'b1;
        num_o   = 6'(i);
        rank_o  = rank_i[i];
      end
    end
  end

endmodule // priority_resolver

`default_nettype wire

// [exception_priority_unit.sv]
// Exception prioritisation and entry sequencing between sources and the core.
// Assumes the core answers each stack, unstack and fetch command with a done pulse.
`default_nettype none

// Notes on behaviour
// - Every exception except reset runs in handler mode
// - State stacked on entry, unstacked on return
// - Vector fetched in parallel with stacking
// - Pending exception at return chains without restacking
// - Eight settable levels, seven handlers, 29 interrupts
// - Group part alone decides pre-emption
// - Settable zero ranks below reset, NMI, hard fault
// - Settable priorities reset to zero
// - Equal priority: lowest position wins
// - Reset position 1, highest, then base level
// - NMI preempted only by reset, software set
// - Hard fault position 3 catches blocked faults
// - Memory management position 4, protection mismatch
// - Bus fault position 5, enable controlled
// - Usage fault position 6, synchronous
// - Supervisor call position 11
// - Debug monitor position 12, enabled, not halted
// - Pendable service request 14, software set only
// - Periodic tick exception position 15
// - Peripheral interrupts from position 16 upward
// - Fixed peripheral bit assignment, 44-47 reserved
// - Stack top loaded from entry 0 first
// - Reserved address access answered with bus fault
module exception_priority_unit #(
  parameter logic [31:0] FLASH_BYTES = 32'h0001_0000,
  parameter logic [31:0] SRAM_BYTES  = 32'h0001_0000
) (
  // Clock and reset
  input  wire logic                ref_clk_i,
  input  wire logic                sys_rst_i,
  // Peripheral interrupt lines and their enables
  input  wire logic [47:0]         irq_i,
  input  wire logic [47:0]         irq_en_i,
  // System exception events and handler enables
  input  wire epu_pkg::sys_evt_t   sys_evt_i,
  input  wire epu_pkg::fault_en_t  fault_en_i,
  input  wire logic                halted_i,
  // Priority configuration
  input  wire logic [2:0]          prigroup_i,
  input  wire logic                prio_wr_i,
  input  wire logic [5:0]          prio_idx_i,
  input  wire logic [2:0]          prio_val_i,
  // Memory access check
  input  wire epu_pkg::bus_acc_t   bus_acc_i,
  // Answers from the core
  input  wire logic                stack_done_i,
  input  wire logic                fetch_done_i,
  input  wire logic                exc_return_i,
  input  wire logic                first_instr_i,
  // Outputs
  output epu_pkg::core_cmd_t       core_cmd_o,
  output logic                     handler_mode_o,
  output logic [5:0]               active_num_o,
  output logic [63:0]              pend_o,
  output logic                     bus_fault_resp_o
);

  epu_pkg::state_t  st;
  epu_pkg::state_t  next_st;

  logic [63:0]      settable;
  logic [63:0]      pendable;
  logic [2:0]       grp_mask;
  logic [63:0][4:0] rank;
  logic [63:0][4:0] grp_rank;
  logic             win_found;
  logic [5:0]       win_num;
  logic [4:0]       win_rank;
  logic             act_found;
  logic [5:0]       act_num;
  logic [4:0]       act_rank;
  logic [4:0]       cur_lvl;
  logic             win_preempts;
  logic             reserved_hit;
  logic [63:0]      set_vec;

  // Positions that exist and positions whose priority software sets
  assign settable = {epu_pkg::IRQ_VALID, epu_pkg::SYS_SETTABLE};
  assign pendable = {epu_pkg::IRQ_VALID, epu_pkg::SYS_PENDABLE};

  // Group mask from the split setting; low bits become subpriority
  always_comb begin
    unique case (prigroup_i)
      3'h5:    grp_mask = 3'h6;
      3'h6:    grp_mask = 3'h4;
      3'h7:    grp_mask = 3'h0;
      default: grp_mask = 3'h7;
    endcase
  end

  // Rank per position: fixed levels below settable zero
  for (genvar i = 0; i < epu_pkg::NUM_POS; i++) begin : g_rank
    if (i == 1 || i == 2 || i == 3) begin : g_fixed
      assign rank[i]     = 5'(i - 1);
      assign grp_rank[i] = 5'(i - 1);
    end else begin : g_set
      assign rank[i]     = epu_pkg::RANK_SETTABLE_BASE + {2'b00, st.prio[i]};
      assign grp_rank[i] = epu_pkg::RANK_SETTABLE_BASE
                         + {2'b00, st.prio[i] & grp_mask};
    end
  end

  // Most urgent pending position, ties to the lowest number
  priority_resolver u_pend_pick (
    .req_i   (st.pend),
    .rank_i  (rank),
    .found_o (win_found),
    .num_o   (win_num),
    .rank_o  (win_rank)
  );

  // Running exception is the most urgent active one
  priority_resolver u_act_pick (
    .req_i   (st.active),
    .rank_i  (rank),
    .found_o (act_found),
    .num_o   (act_num),
    .rank_o  (act_rank)
  );

  // Current activation level; base level when nothing is active
  assign cur_lvl      = act_found ? grp_rank[act_num] : epu_pkg::RANK_BASE_LEVEL;
  assign win_preempts = win_found && (grp_rank[win_num] < cur_lvl);

  // Address check against the mapped windows
  always_comb begin
    logic mapped;
    mapped = 1'b0;
    if (bus_acc_i.addr < FLASH_BYTES) begin
      mapped = 1'b1;
    end
    if (bus_acc_i.addr >= epu_pkg::SRAM_BASE
        && bus_acc_i.addr - epu_pkg::SRAM_BASE < SRAM_BYTES) begin
      mapped = 1'b1;
    end
    if (bus_acc_i.addr >= epu_pkg::TRACE_LO && bus_acc_i.addr <= epu_pkg::TRACE_HI) begin
      mapped = 1'b1;
    end
    for (int k = 0; k < epu_pkg::MAP_N; k++) begin
      if (bus_acc_i.addr >= epu_pkg::MAP_LO[k] && bus_acc_i.addr <= epu_pkg::MAP_HI[k]) begin
        mapped = 1'b1;
      end
    end
    reserved_hit = bus_acc_i.valid && !mapped;
  end

  // Pending sources, with blocked faults escalated to hard fault
  always_comb begin
    set_vec = 64'h0;
    set_vec[epu_pkg::POS_NMI] = sys_evt_i.nmi_set;
    // Memory management fault
    if (sys_evt_i.mem_fault) begin
      if (fault_en_i.mem_en && grp_rank[epu_pkg::POS_MEM] < cur_lvl) begin
        set_vec[epu_pkg::POS_MEM] = 1'b1;
      end else begin
        set_vec[epu_pkg::POS_HARD] = 1'b1;
      end
    end
    // Bus fault, from the core or from a reserved access
    if (sys_evt_i.bus_fault || reserved_hit) begin
      if (fault_en_i.bus_en && grp_rank[epu_pkg::POS_BUS] < cur_lvl) begin
        set_vec[epu_pkg::POS_BUS] = 1'b1;
      end else begin
        set_vec[epu_pkg::POS_HARD] = 1'b1;
      end
    end
    // Usage fault
    if (sys_evt_i.usage_fault) begin
      if (fault_en_i.usage_en && grp_rank[epu_pkg::POS_USAGE] < cur_lvl) begin
        set_vec[epu_pkg::POS_USAGE] = 1'b1;
      end else begin
        set_vec[epu_pkg::POS_HARD] = 1'b1;
      end
    end
    set_vec[epu_pkg::POS_SVC]    = sys_evt_i.svc;
    set_vec[epu_pkg::POS_DEBUG]  = sys_evt_i.debug_event
                                 && fault_en_i.debug_en && !halted_i;
    set_vec[epu_pkg::POS_PENDABLE_SERVICE_REQUEST] = sys_evt_i.pendable_service_request_set;
    set_vec[epu_pkg::POS_TICK]   = sys_evt_i.tick;
    // Peripheral lines pend while enabled and not already being serviced
    set_vec[63:16] = irq_i & irq_en_i & ~st.active[63:16];
    set_vec = set_vec & pendable;
  end

  // Next state: priority writes, pending set, and the entry/exit sequencer
  always_comb begin
    next_st = st;
    next_st.bus_fault_resp = reserved_hit;
    // Priority writes land only on settable positions
    if (prio_wr_i && settable[prio_idx_i]) begin
      next_st.prio[prio_idx_i] = prio_val_i;
    end
    // Command handshakes
    if (stack_done_i) begin
      next_st.cmd.stack_push = 1'b0;
      next_st.cmd.unstack    = 1'b0;
      next_st.stack_ok       = 1'b1;
    end
    if (fetch_done_i) begin
      next_st.cmd.vec_fetch = 1'b0;
      next_st.cmd.sp_load   = 1'b0;
      next_st.fetch_ok      = 1'b1;
    end
    unique case (st.phase)
      // Stack top from entry 0 before the reset vector
      epu_pkg::PH_SP_LOAD: begin
        if (fetch_done_i) begin
          next_st.phase         = epu_pkg::PH_RST_VEC;
          next_st.cmd.vec_fetch = 1'b1;
          next_st.cmd.vec_num   = epu_pkg::POS_RESET;
        end
      end
      // Reset vector fetch; reset is then the active exception
      epu_pkg::PH_RST_VEC: begin
        if (fetch_done_i) begin
          next_st.phase                     = epu_pkg::PH_RESET_RUN;
          next_st.active[epu_pkg::POS_RESET] = 1'b1;
          next_st.cur_num                   = epu_pkg::POS_RESET;
        end
      end
      // First instruction drops to the base activation level
      epu_pkg::PH_RESET_RUN: begin
        if (first_instr_i) begin
          next_st.phase                     = epu_pkg::PH_RUN;
          next_st.active[epu_pkg::POS_RESET] = 1'b0;
        end
      end
      // Running: take a return or a pre-empting exception
      epu_pkg::PH_RUN: begin
        if (exc_return_i && st.handler) begin
          next_st.phase               = epu_pkg::PH_EXIT;
          next_st.active[st.cur_num]  = 1'b0;
        end else if (win_preempts) begin
          next_st.phase              = epu_pkg::PH_ENTRY;
          next_st.pend[win_num]      = 1'b0;
          next_st.active[win_num]    = 1'b1;
          next_st.cur_num            = win_num;
          next_st.cmd.stack_push     = 1'b1;
          next_st.cmd.vec_fetch      = 1'b1;
          next_st.cmd.vec_num        = win_num;
          next_st.stack_ok           = 1'b0;
          next_st.fetch_ok           = 1'b0;
        end
      end
      // Entry completes once both stacking and fetch are done
      epu_pkg::PH_ENTRY: begin
        if ((st.stack_ok || stack_done_i) && (st.fetch_ok || fetch_done_i)) begin
          next_st.phase   = epu_pkg::PH_RUN;
          next_st.handler = 1'b1;
        end
      end
      // After a return: chain into a pending exception or unstack
      epu_pkg::PH_EXIT: begin
        if (win_preempts) begin
          next_st.phase           = epu_pkg::PH_ENTRY;
          next_st.pend[win_num]   = 1'b0;
          next_st.active[win_num] = 1'b1;
          next_st.cur_num         = win_num;
          next_st.cmd.vec_fetch   = 1'b1;
          next_st.cmd.vec_num     = win_num;
          next_st.stack_ok        = 1'b1;
          next_st.fetch_ok        = 1'b0;
        end else begin
          next_st.phase       = epu_pkg::PH_UNSTACK;
          next_st.cmd.unstack = 1'b1;
          next_st.stack_ok    = 1'b0;
        end
      end
      // Restore state; return to the interrupted handler or to thread mode
      epu_pkg::PH_UNSTACK: begin
        if (stack_done_i) begin
          next_st.phase   = epu_pkg::PH_RUN;
          next_st.handler = act_found;
          next_st.cur_num = act_found ? act_num : 6'h00;
        end
      end
      default: begin
        next_st.phase = epu_pkg::PH_SP_LOAD;
      end
    endcase
    // New events win over the clear of an activation in the same cycle
    next_st.pend = (next_st.pend | set_vec) & pendable;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st             <= '0;
      st.phase       <= epu_pkg::PH_SP_LOAD;
      st.prio        <= {epu_pkg::NUM_POS{epu_pkg::PRIO_RESET}};
      st.cmd.sp_load <= 1'b1;
      st.cmd.vec_num <= epu_pkg::POS_STACK_TOP;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign core_cmd_o       = st.cmd;
  assign handler_mode_o   = st.handler;
  assign active_num_o     = st.cur_num;
  assign pend_o           = st.pend;
  assign bus_fault_resp_o = st.bus_fault_resp;

endmodule // exception_priority_unit

`default_nettype wire

// [epu_checker_sva.sv]
// Concurrent checks on the ports of the exception priority unit.
// Assumes one clock domain with a synchronous active-high reset.
`default_nettype none

module epu_checker #(
  parameter logic [31:0] FLASH_BYTES = 32'h0001_0000,
  parameter logic [31:0] SRAM_BYTES  = 32'h0001_0000
) (
  // Clock and reset
  input wire logic               ref_clk_i,
  input wire logic               sys_rst_i,
  // Sources and configuration
  input wire logic [47:0]        irq_i,
  input wire logic [47:0]        irq_en_i,
  input wire epu_pkg::sys_evt_t  sys_evt_i,
  input wire epu_pkg::fault_en_t fault_en_i,
  input wire logic               halted_i,
  input wire logic [2:0]         prigroup_i,
  input wire logic               prio_wr_i,
  input wire logic [5:0]         prio_idx_i,
  input wire logic [2:0]         prio_val_i,
  input wire epu_pkg::bus_acc_t  bus_acc_i,
  // Core answers
  input wire logic               stack_done_i,
  input wire logic               fetch_done_i,
  input wire logic               exc_return_i,
  input wire logic               first_instr_i,
  // Unit outputs
  input wire epu_pkg::core_cmd_t core_cmd_o,
  input wire logic               handler_mode_o,
  input wire logic [5:0]         active_num_o,
  input wire logic [63:0]        pend_o,
  input wire logic               bus_fault_resp_o
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  // Entry ordering and stacking
  push_fetch_a: assert property (
    $rose(core_cmd_o.stack_push) |-> core_cmd_o.vec_fetch)
    else $error("stack push without vector fetch");
  boot_stack_top_a: assert property (
    $fell(sys_rst_i) |-> core_cmd_o.sp_load && core_cmd_o.vec_num == 6'h00 && !handler_mode_o)
    else $error("stack top not loaded first after reset");
  push_holds_a: assert property (
    core_cmd_o.stack_push && !stack_done_i |=> core_cmd_o.stack_push)
    else $error("stack push dropped before done");
  chain_no_push_a: assert property (
    exc_return_i && handler_mode_o
    && {core_cmd_o.sp_load, core_cmd_o.stack_push, core_cmd_o.unstack, core_cmd_o.vec_fetch} == 4'h0
    |-> ##2 !core_cmd_o.stack_push && (core_cmd_o.vec_fetch != core_cmd_o.unstack))
    else $error("return did not chain or unstack");
  nmi_wins_a: assert property (
    $rose(core_cmd_o.stack_push) && $past(pend_o[2]) |-> core_cmd_o.vec_num == 6'h02)
    else $error("pending nmi passed over");

  // Pending state
  no_reserved_pend_a: assert property (
    (pend_o & ~{epu_pkg::IRQ_VALID, epu_pkg::SYS_PENDABLE}) == 64'h0)
    else $error("reserved position pending");
  hard_escalate_a: assert property (
    sys_evt_i.usage_fault && !fault_en_i.usage_en |=> pend_o[3])
    else $error("disabled fault not escalated");
  halted_debug_a: assert property (
    sys_evt_i.debug_event && halted_i && !pend_o[12] |=> !pend_o[12])
    else $error("debug monitor pended while halted");
  pendable_service_request_sets_a: assert property (
    sys_evt_i.pendable_service_request_set |=> pend_o[14])
    else $error("service request not pended");

  // Reserved address answer
  reserved_addr_a: assert property (
    bus_acc_i.valid && bus_acc_i.addr[31:12] == 20'h40001 |=> bus_fault_resp_o)
    else $error("reserved access not faulted");
endmodule // epu_checker

bind exception_priority_unit epu_checker #(
  .FLASH_BYTES(FLASH_BYTES),
  .SRAM_BYTES (SRAM_BYTES)
) chk (.*);

`default_nettype wire

// [core_model.sv]
// Behavioural core that answers stack and fetch commands with done pulses.
// Assumes each command stands until the done pulse that answers it.
`default_nettype none

module core_model (
  // Clock and reset
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  // Commands and answer latency
  input  wire epu_pkg::core_cmd_t cmd_i,
  input  wire logic [3:0]         lat_i,
  // Answers
  output logic                    stack_done_o,
  output logic                    fetch_done_o,
  output logic                    first_instr_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] stack_cnt;
  logic [3:0] fetch_cnt;
  logic       boot_end;

  // Each command answered once, lat_i+1 cycles after it appears; boot ends after vector 1
  always @(posedge ref_clk_i) begin
    stack_done_o  <= 1'b0;
    fetch_done_o  <= 1'b0;
    first_instr_o <= boot_end;
    boot_end      <= 1'b0;
    if (sys_rst_i) begin
      stack_cnt <= 4'h0;
      fetch_cnt <= 4'h0;
    end else begin
      if ((cmd_i.stack_push || cmd_i.unstack) && !stack_done_o) begin
        stack_cnt <= stack_cnt + 4'h1;
        if (stack_cnt >= lat_i) begin
          stack_done_o <= 1'b1;
          stack_cnt    <= 4'h0;
        end
      end
      if ((cmd_i.sp_load || cmd_i.vec_fetch) && !fetch_done_o) begin
        fetch_cnt <= fetch_cnt + 4'h1;
        if (fetch_cnt >= lat_i) begin
          fetch_done_o <= 1'b1;
          fetch_cnt    <= 4'h0;
          boot_end     <= cmd_i.vec_fetch && cmd_i.vec_num == 6'h01;
        end
      end
    end
  end
endmodule // core_model

`default_nettype wire

// [test_exception_priority_unit.sv]
// Self-checking bench of the exception priority unit with a core model.
// Assumes the 25 MHz system clock and inputs driven 1 ns after each edge.
`default_nettype none

module test_exception_priority_unit;
  timeunit 1ns;
  timeprecision 1ps;

  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [47:0]        irq = '0;
  logic [47:0]        irq_en = '1;
  epu_pkg::sys_evt_t  evt = '0;
  epu_pkg::fault_en_t fen = '1;
  logic               halted = 1'b0;
  logic [2:0]         prigroup = 3'h0;
  logic               prio_wr = 1'b0;
  logic [5:0]         prio_idx = 6'h00;
  logic [2:0]         prio_val = 3'h0;
  epu_pkg::bus_acc_t  acc = '0;
  logic               exc_ret = 1'b0;
  logic [3:0]         lat = 4'h2;
  logic               stack_done;
  logic               fetch_done;
  logic               first_instr;
  epu_pkg::core_cmd_t cmd;
  logic               handler;
  logic [5:0]         active;
  logic [63:0]        pend;
  logic               resp;
  int                 num_errors = 0;
  int                 tests_run = 0;
  logic [5:0]         pos [8] = '{6'h0f, 6'h0e, 6'h0c, 6'h0b, 6'h06, 6'h05, 6'h04, 6'h02};

  // Unit and the core that answers it
  exception_priority_unit dut (.ref_clk_i(clk), .sys_rst_i(rst), .irq_i(irq), .irq_en_i(irq_en),
    .sys_evt_i(evt), .fault_en_i(fen), .halted_i(halted), .prigroup_i(prigroup),
    .prio_wr_i(prio_wr), .prio_idx_i(prio_idx), .prio_val_i(prio_val), .bus_acc_i(acc),
    .stack_done_i(stack_done), .fetch_done_i(fetch_done), .exc_return_i(exc_ret),
    .first_instr_i(first_instr), .core_cmd_o(cmd), .handler_mode_o(handler),
    .active_num_o(active), .pend_o(pend), .bus_fault_resp_o(resp));
  core_model model (.ref_clk_i(clk), .sys_rst_i(rst), .cmd_i(cmd), .lat_i(lat),
    .stack_done_o(stack_done), .fetch_done_o(fetch_done), .first_instr_o(first_instr));

  // Clock
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Waits for a fetch or unstack command, bounded
  task automatic next_cmd();
    int i;
    i = 0;
    while (cmd.vec_fetch !== 1'b1 && cmd.unstack !== 1'b1 && i < 300) begin
      step(1);
      i++;
    end
    check("command seen", 64'(i < 300), 64'h1);
  endtask

  // Waits until every command has been answered
  task automatic settle();
    int i;
    i = 0;
    while ({cmd.sp_load, cmd.stack_push, cmd.unstack, cmd.vec_fetch} !== 4'h0 && i < 300) begin
      step(1);
      i++;
    end
    check("commands answered", 64'(i < 300), 64'h1);
    step(2);
  endtask

  task automatic enter(input logic [5:0] n, input logic chain);
    next_cmd();
    check("vector", 64'(cmd.vec_num), 64'(n));
    check("stacking", 64'(cmd.stack_push), 64'(!chain));
    settle();
    check("handler", 64'(handler), 64'h1);
    check("active", 64'(active), 64'(n));
  endtask

  task automatic leave(input logic unst);
    exc_ret = 1'b1;
    step(1);
    exc_ret = 1'b0;
    if (unst) begin
      next_cmd();
      check("unstack", 64'(cmd.unstack), 64'h1);
      check("refetch", 64'(cmd.vec_fetch), 64'h0);
      settle();
    end
  endtask

  task automatic wprio(input logic [5:0] p, input logic [2:0] v);
    prio_idx = p;
    prio_val = v;
    prio_wr = 1'b1;
    step(1);
    prio_wr = 1'b0;
    step(1);
  endtask

  task automatic pulse_irq(input logic [47:0] b);
    irq = b;
    step(1);
    irq = '0;
  endtask

  // Reset, stack top load, reset vector and first instruction
  task automatic t_boot();
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    check("sp load", 64'(cmd.sp_load), 64'h1);
    check("stack top", 64'(cmd.vec_num), 64'h0);
    check("pend clear", pend, 64'h0);
    next_cmd();
    check("reset vector", 64'(cmd.vec_num), 64'h1);
    settle();
    step(2);
    check("thread", 64'(handler), 64'h0);
    $display("test boot finished");
  endtask

  // Equal priorities, tail chain, then unlisted lines
  task automatic t_tie();
    pulse_irq(48'h3);
    enter(6'h10, 1'b0);
    check("second pend", 64'(pend[17]), 64'h1);
    leave(1'b0);
    enter(6'h11, 1'b1);
    leave(1'b1);
    check("back to thread", 64'(handler), 64'h0);
    irq = 48'hff7e_0000_3e00;
    step(3);
    irq = '0;
    check("unlisted lines", pend, 64'h0);
    $display("test tie finished");
  endtask

  // Settable levels, nmi pre-emption and subpriority grouping
  task automatic t_prio();
    wprio(6'h10, 3'h5);
    wprio(6'h11, 3'h2);
    pulse_irq(48'h3);
    enter(6'h11, 1'b0);
    evt.nmi_set = 1'b1;
    step(1);
    evt = '0;
    enter(6'h02, 1'b0);
    leave(1'b1);
    check("nested", 64'(active), 64'h11);
    leave(1'b0);
    enter(6'h10, 1'b1);
    leave(1'b1);
    prigroup = 3'h7;
    wprio(6'h10, 3'h0);
    pulse_irq(48'h2);
    enter(6'h11, 1'b0);
    pulse_irq(48'h1);
    step(8);
    check("no preempt", 64'(active), 64'h11);
    leave(1'b0);
    enter(6'h10, 1'b1);
    leave(1'b1);
    prigroup = 3'h0;
    $display("test prio finished");
  endtask

  // Each system event, a disabled fault and a halted debug event
  task automatic t_events();
    for (int i = 0; i < 8; i++) begin
      evt = epu_pkg::sys_evt_t'(8'h01 << i);
      step(1);
      evt = '0;
      enter(pos[i], 1'b0);
      leave(1'b1);
    end
    fen = '0;
    evt.usage_fault = 1'b1;
    step(1);
    evt = '0;
    enter(6'h03, 1'b0);
    leave(1'b1);
    fen = '1;
    halted = 1'b1;
    evt.debug_event = 1'b1;
    step(1);
    evt = '0;
    step(3);
    check("halted debug", 64'(pend[12]), 64'h0);
    halted = 1'b0;
    $display("test events finished");
  endtask

  // Mapped and reserved accesses
  task automatic t_addr();
    logic [31:0] a [3] = '{32'h4000_4000, 32'h4000_1000, 32'h0002_0000};
    for (int i = 0; i < 3; i++) begin
      acc = '{1'b1, a[i]};
      step(1);
      acc.valid = 1'b0;
      check("fault answer", 64'(resp), 64'(i != 0));
      step(1);
      if (i != 0) begin
        enter(6'h05, 1'b0);
        leave(1'b1);
      end
    end
    $display("test addr finished");
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    t_boot();
    lat = 4'h3;
    t_tie();
    t_prio();
    lat = 4'h0;
    t_events();
    t_addr();
    wprio(6'h10, 3'h7);
    t_boot();
    t_tie();
    report_and_stop();
  end

  // Watchdog
  initial begin
    #800000;
    num_errors++;
    report_and_stop();
  end
endmodule // test_exception_priority_unit

`default_nettype wire
